/* File: pkg/prot_defs.vh */
`ifndef PROT_DEFS_VH
`define PROT_DEFS_VH

// Register byte addresses
`define A_CTRL        8'h00
`define A_STATUS      8'h04
`define A_RATIO_A     8'h08
`define A_RATIO_B     8'h0c
`define A_BASE        8'h10
`define A_RELAY_REQ   8'h14
`define A_CHMAP       8'h18
`define A_GRPORD      8'h1c
`define A_GRP_FIRST   8'h20
`define A_GRP_LAST    8'h7f
`define A_ID_FIRST    8'h80
`define A_ID_LAST     8'hcf

// Control field positions
`define C_FUNC_EN     0
`define C_EVENTS_EN   1
`define C_PROGRAMMED  2
`define C_GRP_LO      3
`define C_GRP_HI      5
`define C_MODE_LO     6
`define C_MODE_HI     7

// Comparator modes
`define MODE_OVER     2'h0
`define MODE_UNDER    2'h1
`define MODE_RANGE    2'h2

// Setting groups and identifier
`define NUM_GROUPS    6
`define GRP_FIRST     3'h1
`define GRP_LAST      3'h6
`define ID_CHARS      20
`define GRPS_PER_SLOT 8'h06

// Reset values
`define RATIO_RST     16'h0001
`define BASE_RST      16'h01f4
`define ID_CHAR_RST   8'h2d

// Evaluation tick
`define CLK_PERIOD_NS  10
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES    (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* File: design/pu_compare.v */
`timescale 1ns/1ns
`include "prot_defs.vh"

module pu_compare #(
    parameter W = 16
) (
    input  wire          sys_clk,
    input  wire          reset,
    input  wire          clk_en,
    input  wire          run,
    input  wire [1:0]    mode,
    input  wire [W-1:0]  meas_a,
    input  wire [W-1:0]  meas_b,
    input  wire [W-1:0]  ratio_a,
    input  wire [W-1:0]  ratio_b,
    input  wire [W-1:0]  base,
    input  wire [W-1:0]  pk_lo,
    input  wire [W-1:0]  pk_hi,
    output reg           pickup
);
    // Levels in thousandths of a per-unit
    localparam [9:0] MILLI = 10'h3e8;
    localparam AW = 3 * W + 2;

    wire [W-1:0]    big_ratio = (ratio_a >= ratio_b) ? ratio_a : ratio_b;
    // Sum referred to the larger-ratio CT, times that ratio
    wire [2*W:0]    sum_a     = {1'b0, {{W{1'b0}}, meas_a} * {{W{1'b0}}, ratio_a}}
                              + {1'b0, {{W{1'b0}}, meas_b} * {{W{1'b0}}, ratio_b}};
    wire [AW-1:0]   act_k     = {{(AW-2*W-1){1'b0}}, sum_a} * {{(AW-10){1'b0}}, MILLI};
    wire [2*W-1:0]  base_k    = {{W{1'b0}}, base} * {{W{1'b0}}, big_ratio};
    wire [AW-1:0]   lo_k      = {{(W+2){1'b0}}, base_k} * {{(2*W+2){1'b0}}, pk_lo};
    wire [AW-1:0]   hi_k      = {{(W+2){1'b0}}, base_k} * {{(2*W+2){1'b0}}, pk_hi};
    reg             hit;

    always @*
    begin
        case (mode)
            `MODE_OVER:  hit = act_k > lo_k;
            `MODE_UNDER: hit = act_k < lo_k;
            `MODE_RANGE: hit = (act_k >= lo_k) && (act_k <= hi_k);
            default:     hit = 1'b0;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (reset)
            pickup <= 1'b0;
        else if (clk_en)
            pickup <= run ? hit : 1'b0;
    end
endmodule // pu_compare

/* File: design/delay_timer.v */
`timescale 1ns/1ns

module delay_timer #(
    parameter W = 16
) (
    input  wire          sys_clk,
    input  wire          reset,
    input  wire          clk_en,
    input  wire          tick,
    input  wire          run,
    input  wire          pickup,
    input  wire [W-1:0]  pkp_delay,
    input  wire [W-1:0]  rst_delay,
    output reg           operate
);
    reg [W-1:0] cnt_r;

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            cnt_r   <= {W{1'b0}};
            operate <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!run)
            begin
                cnt_r   <= {W{1'b0}};
                operate <= 1'b0;
            end
            else if (!operate)
            begin
                if (!pickup)
                    cnt_r <= {W{1'b0}};
                else if (cnt_r >= pkp_delay)
                begin
                    operate <= 1'b1;
                    cnt_r   <= {W{1'b0}};
                end
                else if (tick)
                    cnt_r <= cnt_r + 1'b1;
            end
            else
            begin
                if (pickup)
                    cnt_r <= {W{1'b0}};
                else if (cnt_r >= rst_delay)
                begin
                    operate <= 1'b0;
                    cnt_r   <= {W{1'b0}};
                end
                else if (tick)
                    cnt_r <= cnt_r + 1'b1;
            end
        end
    end
endmodule // delay_timer

/* File: design/prot_supervisor.v */
// Operation
// - Comparator output low unless run is high
// - Block input forces run low
// - Pickup above, below or within set range
// - Operate after pickup held for pickup delay
// - Operate holds for reset delay after dropout
// - Element inactive until function enabled
// - Events setting gates pickup, dropout, trip events
// - Dropout event on every pickup fall
// - Six setting groups, active one used
// - Relays inhibited and error until programmed
// - Twenty-character identifier stored and readable
// - Per-unit equals actual over base
// - Smaller-ratio CT scaled to larger ratio
// - Twelve channels mapped to fixed types
// - Groups ordered by block, then slot (code numbers them by slot, then block: slot * 6 + block)
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "prot_defs.vh"

module prot_supervisor #(
    parameter W           = 16,
    parameter NUM_RELAYS  = 8,
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    input  wire                   sys_clk,
    input  wire                   reset,
    input  wire                   clk_en,
    input  wire [7:0]             reg_addr,
    input  wire [31:0]            reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [31:0]            reg_rdata,
    input  wire [W-1:0]           meas_a,
    input  wire [W-1:0]           meas_b,
    input  wire                   block_in,
    output reg                    pickup_out,
    output reg                    operate_out,
    output reg                    pickup_event,
    output reg                    dropout_event,
    output reg                    trip_event,
    output reg  [NUM_RELAYS-1:0]  relay_out,
    output reg                    unprog_err
);
    localparam TW = 32;
    localparam [TW-1:0] TICK_LAST = TICK_CYCLES - 1;

    // Control and settings
    reg [7:0]            ctrl_r;
    reg [W-1:0]          ratio_a_r;
    reg [W-1:0]          ratio_b_r;
    reg [W-1:0]          base_r;
    reg [NUM_RELAYS-1:0] relay_req_r;
    reg [3:0]            ord_slot_r;
    reg [3:0]            ord_chan_r;
    reg [W-1:0]          grp_lo   [0:`NUM_GROUPS-1];
    reg [W-1:0]          grp_hi   [0:`NUM_GROUPS-1];
    reg [W-1:0]          grp_pkp  [0:`NUM_GROUPS-1];
    reg [W-1:0]          grp_rst  [0:`NUM_GROUPS-1];
    reg [7:0]            id_mem   [0:`ID_CHARS-1];

    reg                  block_meta_r;
    reg                  block_r;
    reg [TW-1:0]         tick_cnt_r;
    reg                  tick_r;
    reg                  pickup_d_r;
    reg                  operate_d_r;

    wire                 func_en    = ctrl_r[`C_FUNC_EN];
    wire                 events_en  = ctrl_r[`C_EVENTS_EN];
    wire                 programmed = ctrl_r[`C_PROGRAMMED];
    wire [2:0]           act_grp    = ctrl_r[`C_GRP_HI:`C_GRP_LO];
    wire [1:0]           cmp_mode   = ctrl_r[`C_MODE_HI:`C_MODE_LO];
    // Group field is 1..6, arrays are 0..5
    wire [2:0]           grp_idx    = act_grp - `GRP_FIRST;
    wire                 run        = func_en & ~block_r;
    wire                 cmp_pickup;
    wire                 tmr_operate;

    wire                 in_grp     = (reg_addr >= `A_GRP_FIRST) && (reg_addr <= `A_GRP_LAST);
    wire [7:0]           grp_off    = reg_addr - `A_GRP_FIRST;
    wire [2:0]           wr_grp     = grp_off[6:4];
    wire                 in_id      = (reg_addr >= `A_ID_FIRST) && (reg_addr <= `A_ID_LAST);
    wire [7:0]           id_off     = reg_addr - `A_ID_FIRST;
    wire [4:0]           id_idx     = id_off[6:2];

    // Channel types: 0 none, 1 three-phase I, 2 single-phase I, 3 voltage
    function [23:0] chan_map;
        input dummy;
        begin
            chan_map = {2'h3, 2'h3, 2'h3,
                        2'h3, 2'h3,
                        2'h2,
                        2'h1, 2'h1, 2'h1,
                        2'h1, 2'h1, 2'h1};
        end
    endfunction

    // Block of a channel within its module, in ascending order
    function [2:0] chan_block;
        input [3:0] chan;
        begin
            case (chan)
                4'h1, 4'h2, 4'h3:    chan_block = 3'h0;
                4'h4, 4'h5, 4'h6:    chan_block = 3'h1;
                4'h7:                chan_block = 3'h2;
                4'h8:                chan_block = 3'h3;
                4'h9:                chan_block = 3'h4;
                4'ha, 4'hb, 4'hc:    chan_block = 3'h5;
                default:             chan_block = 3'h0;
            endcase
        end
    endfunction

    // Enumeration index of a group: slot first weight, block second
    wire [7:0] grp_order = {4'h0, ord_slot_r} * `GRPS_PER_SLOT
                         + {5'h0, chan_block(ord_chan_r)};

    // Block input from a pin
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            block_meta_r <= 1'b0;
            block_r      <= 1'b0;
        end
        else if (clk_en)
        begin
            block_meta_r <= block_in;
            block_r      <= block_meta_r;
        end
    end

    // Evaluation tick
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            tick_cnt_r <= {TW{1'b0}};
            tick_r     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (tick_cnt_r >= TICK_LAST)
            begin
                tick_cnt_r <= {TW{1'b0}};
                tick_r     <= 1'b1;
            end
            else
            begin
                tick_cnt_r <= tick_cnt_r + 1'b1;
                tick_r     <= 1'b0;
            end
        end
    end

    pu_compare #(
        .W       (W)
    ) u_cmp (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .run     (run),
        .mode    (cmp_mode),
        .meas_a  (meas_a),
        .meas_b  (meas_b),
        .ratio_a (ratio_a_r),
        .ratio_b (ratio_b_r),
        .base    (base_r),
        .pk_lo   (grp_lo[grp_idx]),
        .pk_hi   (grp_hi[grp_idx]),
        .pickup  (cmp_pickup)
    );

    delay_timer #(
        .W         (W)
    ) u_tmr (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .tick      (tick_r),
        .run       (run),
        .pickup    (cmp_pickup),
        .pkp_delay (grp_pkp[grp_idx]),
        .rst_delay (grp_rst[grp_idx]),
        .operate   (tmr_operate)
    );

    // Outputs, events and relay gating
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            pickup_d_r    <= 1'b0;
            operate_d_r   <= 1'b0;
            pickup_out    <= 1'b0;
            operate_out   <= 1'b0;
            pickup_event  <= 1'b0;
            dropout_event <= 1'b0;
            trip_event    <= 1'b0;
            relay_out     <= {NUM_RELAYS{1'b0}};
            unprog_err    <= 1'b1;
        end
        else if (clk_en)
        begin
            pickup_d_r    <= cmp_pickup;
            operate_d_r   <= tmr_operate;
            pickup_out    <= cmp_pickup;
            operate_out   <= tmr_operate;
            pickup_event  <= events_en & cmp_pickup & ~pickup_d_r;
            dropout_event <= events_en & ~cmp_pickup & pickup_d_r;
            trip_event    <= events_en & tmr_operate & ~operate_d_r;
            if (programmed)
                relay_out <= {relay_req_r[NUM_RELAYS-1:1], tmr_operate};
            else
                relay_out <= {NUM_RELAYS{1'b0}};
            unprog_err    <= ~programmed;
        end
    end

    // Register writes
    integer i;
    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctrl_r      <= {2'h0, 3'h1, 3'h0};
            ratio_a_r   <= `RATIO_RST;
            ratio_b_r   <= {W{1'b0}};
            base_r      <= `BASE_RST;
            relay_req_r <= {NUM_RELAYS{1'b0}};
            ord_slot_r  <= 4'h0;
            ord_chan_r  <= 4'h1;
            for (i = 0; i < `NUM_GROUPS; i = i + 1)
            begin
                grp_lo[i]  <= {W{1'b0}};
                grp_hi[i]  <= {W{1'b0}};
                grp_pkp[i] <= {W{1'b0}};
                grp_rst[i] <= {W{1'b0}};
            end
            for (i = 0; i < `ID_CHARS; i = i + 1)
                id_mem[i] <= `ID_CHAR_RST;
        end
        else if (clk_en && reg_wr)
        begin
            if (reg_addr == `A_CTRL)
            begin
                ctrl_r[2:0] <= reg_wdata[2:0];
                ctrl_r[7:6] <= reg_wdata[7:6];
                // Only groups 1..6 are taken
                if (reg_wdata[5:3] >= `GRP_FIRST && reg_wdata[5:3] <= `GRP_LAST)
                    ctrl_r[5:3] <= reg_wdata[5:3];
            end
            else if (reg_addr == `A_RATIO_A)
                ratio_a_r <= reg_wdata[W-1:0];
            else if (reg_addr == `A_RATIO_B)
                ratio_b_r <= reg_wdata[W-1:0];
            else if (reg_addr == `A_BASE)
                base_r <= reg_wdata[W-1:0];
            else if (reg_addr == `A_RELAY_REQ)
                relay_req_r <= reg_wdata[NUM_RELAYS-1:0];
            else if (reg_addr == `A_GRPORD)
            begin
                ord_slot_r <= reg_wdata[3:0];
                ord_chan_r <= reg_wdata[7:4];
            end
            else if (in_grp && wr_grp < `NUM_GROUPS)
            begin
                case (grp_off[3:2])
                    2'h0:    grp_lo[wr_grp]  <= reg_wdata[W-1:0];
                    2'h1:    grp_hi[wr_grp]  <= reg_wdata[W-1:0];
                    2'h2:    grp_pkp[wr_grp] <= reg_wdata[W-1:0];
                    default: grp_rst[wr_grp] <= reg_wdata[W-1:0];
                endcase
            end
            else if (in_id && id_idx < `ID_CHARS)
                id_mem[id_idx] <= reg_wdata[7:0];
        end
    end

    // Register reads, data in the following cycle
    reg [31:0] rd_nxt;
    always @*
    begin
        rd_nxt = 32'h0;
        if (reg_addr == `A_CTRL)
            rd_nxt = {24'h0, ctrl_r};
        else if (reg_addr == `A_STATUS)
            rd_nxt = {24'h0, act_grp, unprog_err, block_r, run, operate_out, pickup_out};
        else if (reg_addr == `A_RATIO_A)
            rd_nxt = {{(32-W){1'b0}}, ratio_a_r};
        else if (reg_addr == `A_RATIO_B)
            rd_nxt = {{(32-W){1'b0}}, ratio_b_r};
        else if (reg_addr == `A_BASE)
            rd_nxt = {{(32-W){1'b0}}, base_r};
        else if (reg_addr == `A_RELAY_REQ)
            rd_nxt = {{(32-NUM_RELAYS){1'b0}}, relay_req_r};
        else if (reg_addr == `A_CHMAP)
            rd_nxt = {8'h0, chan_map(1'b0)};
        else if (reg_addr == `A_GRPORD)
            rd_nxt = {16'h0, grp_order, ord_chan_r, ord_slot_r};
        else if (in_grp && wr_grp < `NUM_GROUPS)
        begin
            case (grp_off[3:2])
                2'h0:    rd_nxt = {{(32-W){1'b0}}, grp_lo[wr_grp]};
                2'h1:    rd_nxt = {{(32-W){1'b0}}, grp_hi[wr_grp]};
                2'h2:    rd_nxt = {{(32-W){1'b0}}, grp_pkp[wr_grp]};
                default: rd_nxt = {{(32-W){1'b0}}, grp_rst[wr_grp]};
            endcase
        end
        else if (in_id && id_idx < `ID_CHARS)
            rd_nxt = {24'h0, id_mem[id_idx]};
    end

    always @(posedge sys_clk)
    begin
        if (reset)
            reg_rdata <= 32'h0;
        else if (clk_en)
            reg_rdata <= reg_rd ? rd_nxt : 32'h0;
    end
endmodule // prot_supervisor

/* File: verif/prot_supervisor_props.sv */
`timescale 1ns/1ns

module prot_supervisor_props #(
    parameter NUM_RELAYS = 8
) (
    input wire                  sys_clk,
    input wire                  reset,
    input wire                  reg_rd,
    input wire [31:0]           reg_rdata,
    input wire                  block_in,
    input wire                  pickup_out,
    input wire                  operate_out,
    input wire                  pickup_event,
    input wire                  dropout_event,
    input wire                  trip_event,
    input wire [NUM_RELAYS-1:0] relay_out,
    input wire                  unprog_err
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_blk; block_in [*6] |-> !pickup_out && !operate_out; endproperty
    a_blk: assert property (p_blk) else $error("output while blocked");
    property p_pkev; pickup_event |-> $rose(pickup_out); endproperty
    a_pkev: assert property (p_pkev) else $error("stray pickup event");
    property p_dpev; dropout_event |-> $fell(pickup_out); endproperty
    a_dpev: assert property (p_dpev) else $error("stray dropout event");
    property p_trev; trip_event |-> $rose(operate_out); endproperty
    a_trev: assert property (p_trev) else $error("stray trip event");
    property p_inh; |relay_out |-> !unprog_err; endproperty
    a_inh: assert property (p_inh) else $error("relay while unprogrammed");
    property p_rly; relay_out[0] |-> operate_out; endproperty
    a_rly: assert property (p_rly) else $error("relay without operate");
    property p_opr; $rose(operate_out) |-> $past(pickup_out); endproperty
    a_opr: assert property (p_opr) else $error("operate without pickup");
    property p_one; pickup_event |=> !pickup_event; endproperty
    a_one: assert property (p_one) else $error("event longer than a cycle");
    property p_rdz; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside slot");

    c_trip: cover property (trip_event);
    c_held: cover property (dropout_event && operate_out);
    c_req:  cover property (|relay_out[NUM_RELAYS-1:1]);
endmodule // prot_supervisor_props

/* File: verif/prot_supervisor_bench.sv */
`timescale 1ns/1ns
`include "prot_defs.vh"

module prot_supervisor_bench;
    reg          sys_clk   = 1'b0;
    reg          reset     = 1'b1;
    reg          clk_en    = 1'b1;
    reg  [7:0]   reg_addr  = 8'h00;
    reg  [31:0]  reg_wdata = 32'h0;
    reg          reg_wr    = 1'b0;
    reg          reg_rd    = 1'b0;
    reg  [15:0]  meas_a    = 16'h0;
    reg  [15:0]  meas_b    = 16'h0;
    reg          block_in  = 1'b0;
    wire [31:0]  reg_rdata;
    wire         pickup_out, operate_out, pickup_event;
    wire         dropout_event, trip_event, unprog_err;
    wire [7:0]   relay_out;
    int          mismatches   = 0;
    int          total_checks = 0;
    int          n_pk = 0, n_dp = 0, n_tr = 0, n_dh = 0;
    int          n, p0, d0, t0, h0;
    logic [31:0] rd;
    logic [1:0]  md[8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
    logic [15:0] mv[8] = '{16'd11, 16'd10, 16'd9, 16'd10, 16'd10, 16'd20, 16'd21, 16'd9};
    logic        ex[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    prot_supervisor #(.TICK_CYCLES(4)) u_dut (
        .sys_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .meas_a, .meas_b, .block_in, .pickup_out, .operate_out,
        .pickup_event, .dropout_event, .trip_event, .relay_out, .unprog_err
    );

    initial forever #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        if (pickup_event === 1'b1) n_pk <= n_pk + 1;
        if (dropout_event === 1'b1) n_dp <= n_dp + 1;
        if (trip_event === 1'b1) n_tr <= n_tr + 1;
        if (dropout_event === 1'b1 && operate_out === 1'b1) n_dh <= n_dh + 1;
    end

    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    task fail(input string m);
    begin
        mismatches++;
        $display("CHECK FAILED %0t %s", $time, m);
    end
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
        total_checks++;
        if (got !== exp) fail(m);
    end
    endtask

    task chk_bit(input logic got, input logic exp, input string m);
    begin
        total_checks++;
        if (got !== exp) fail(m);
    end
    endtask

    task chk_span(input int got, input int lo, input int hi, input string m);
    begin
        total_checks++;
        if (got < lo || got > hi) fail(m);
    end
    endtask

    task wr(input [7:0] a, input [31:0] d);
    begin
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    end
    endtask

    task rd_raw(input [7:0] a);
    begin
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
        @(posedge sys_clk);
    end
    endtask

    task rd_chk(input [7:0] a, input [31:0] e, input string m);
    begin
        rd_raw(a);
        chk_word(rd, e, m);
    end
    endtask

    // Control word: mode, group, {programmed, events, function}
    task ctrl(input [2:0] g, input [1:0] mode, input [2:0] f);
    begin
        wr(`A_CTRL, {24'h0, mode, g, f});
        repeat (3) @(posedge sys_clk);
    end
    endtask

    task pk(input [15:0] a, input [15:0] b, input logic e);
    begin
        meas_a <= a;
        meas_b <= b;
        repeat (4) @(posedge sys_clk);
        #1 chk_bit(pickup_out, e, "pickup level");
    end
    endtask

    task wait_op(input logic lvl);
    begin
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        while (operate_out !== lvl && n < 60);
        if (operate_out !== lvl)
        begin
            fail("operate wait timed out");
            print_verdict;
        end
    end
    endtask

    task t_reset;
    begin
        rd_chk(`A_CTRL, 32'h08, "ctrl reset");
        rd_chk(`A_RATIO_A, 32'h1, "ratio a reset");
        rd_chk(`A_RATIO_B, 32'h0, "ratio b reset");
        rd_chk(`A_BASE, 32'h1f4, "base reset");
        rd_chk(`A_ID_FIRST, 32'h2d, "id reset");
        rd_chk(8'hd0, 32'h0, "unmapped read");
        rd_chk(`A_CHMAP, 32'hffe555, "channel map");
        chk_bit(unprog_err, 1'b1, "unprogrammed flag");
        chk_word({24'h0, relay_out}, 32'h0, "relays at reset");
    end
    endtask

    task t_regs;
    begin
        wr(`A_BASE, 32'd10);
        wr(8'h20, 32'd1000);
        wr(8'h24, 32'd2000);
        wr(8'h28, 32'd3);
        wr(8'h2c, 32'd2);
        wr(8'h40, 32'd5000);
        wr(`A_RELAY_REQ, 32'hfe);
        wr(8'hcc, 32'h5a);
        rd_chk(8'hcc, 32'h5a, "last id char");
        wr(`A_GRPORD, 32'h82);
        rd_raw(`A_GRPORD);
        chk_word({24'h0, rd[15:8]}, 32'h0f, "group order");
        wr(`A_GRPORD, 32'hc0);
        rd_raw(`A_GRPORD);
        chk_word({24'h0, rd[15:8]}, 32'h05, "group order");
    end
    endtask

    task t_modes;
    begin
        ctrl(3'h1, `MODE_OVER, 3'b000);
        pk(16'd30, 16'd0, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            ctrl(3'h1, md[i], 3'b001);
            pk(mv[i], 16'd0, ex[i]);
        end
        ctrl(3'h1, 2'h3, 3'b001);
        pk(16'd30, 16'd0, 1'b0);
    end
    endtask

    task t_group;
    begin
        ctrl(3'h3, `MODE_OVER, 3'b001);
        pk(16'd30, 16'd0, 1'b0);
        ctrl(3'h1, `MODE_OVER, 3'b001);
        pk(16'd30, 16'd0, 1'b1);
        ctrl(3'h7, `MODE_OVER, 3'b001);
        rd_raw(`A_STATUS);
        chk_word({29'h0, rd[7:5]}, 32'h1, "group kept");
    end
    endtask

    task t_timer(input logic prog, input logic ev);
    begin
        meas_a <= 16'd0;
        ctrl(3'h1, `MODE_OVER, {prog, ev, 1'b1});
        wait_op(1'b0);
        p0 = n_pk;
        d0 = n_dp;
        t0 = n_tr;
        h0 = n_dh;
        meas_a <= 16'd30;
        wait_op(1'b1);
        chk_span(n, 10, 16, "pickup delay");
        chk_word({24'h0, relay_out}, prog ? 32'hff : 32'h0, "relay outputs");
        chk_bit(unprog_err, !prog, "unprogrammed flag");
        meas_a <= 16'd0;
        wait_op(1'b0);
        chk_span(n, 6, 12, "reset delay");
        chk_word(n_pk - p0, ev, "pickup events");
        chk_word(n_tr - t0, ev, "trip events");
        chk_word(n_dp - d0, ev, "dropout events");
        chk_word(n_dh - h0, ev, "dropout while held");
    end
    endtask

    task t_block;
    begin
        ctrl(3'h1, `MODE_OVER, 3'b001);
        pk(16'd30, 16'd0, 1'b1);
        block_in <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 chk_bit(pickup_out, 1'b0, "blocked pickup");
        chk_bit(operate_out, 1'b0, "blocked operate");
        block_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk_bit(pickup_out, 1'b0, "pickup while sync clears");
        @(posedge sys_clk);
        #1 chk_bit(pickup_out, 1'b1, "unblocked pickup");
    end
    endtask

    // Clock enable low holds every register
    task t_freeze;
    begin
        clk_en <= 1'b0;
        meas_a <= 16'd100;
        repeat (6) @(posedge sys_clk);
        #1 chk_bit(pickup_out, 1'b0, "frozen pickup");
        clk_en <= 1'b1;
        pk(16'd100, 16'd0, 1'b1);
    end
    endtask

    task t_ratio;
    begin
        wr(`A_RATIO_B, 32'd3);
        pk(16'd0, 16'd10, 1'b0);
        pk(16'd0, 16'd11, 1'b1);
        pk(16'd30, 16'd0, 1'b0);
        pk(16'd31, 16'd0, 1'b1);
        wr(`A_BASE, 32'd20);
        pk(16'd31, 16'd0, 1'b0);
    end
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        t_regs;
        t_modes;
        t_group;
        t_timer(1'b0, 1'b1);
        t_timer(1'b1, 1'b0);
        t_block;
        t_ratio;
        t_freeze;
        print_verdict;
    end
endmodule // prot_supervisor_bench

bind prot_supervisor prot_supervisor_props #(.NUM_RELAYS(NUM_RELAYS)) u_props (
    .sys_clk, .reset, .reg_rd, .reg_rdata, .block_in, .pickup_out, .operate_out,
    .pickup_event, .dropout_event, .trip_event, .relay_out, .unprog_err
);
